// ==== atc_top.sv ====
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module atc_top
  import atc_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [RES_W-1:0] RESULT_I,
  input wire logic RESULT_VLD_I,
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [DATA_W-1:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic OVER_FLAG_O,
  output logic UNDER_FLAG_O
);
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic aw_full_q;
  logic aw_full_d;
  logic w_full_q;
  logic w_full_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic bvalid_d;
  atc_resp_t bresp_q;
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [DATA_W-1:0] rdata_q;
  atc_resp_t rresp_q;
  logic [FIELD_W-1:0] low_field_q;
  logic [FIELD_W-1:0] high_field_q;
  logic chan0_over_flag_q;
  logic chan0_over_flag_d;
  logic chan0_under_flag_q;
  logic chan0_under_flag_d;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_wr;
  logic wr_low_ok;
  logic wr_high_ok;
  logic wr_ok;
  logic flag_clear;
  logic [RES_W-1:0] low_int;
  logic [RES_W-1:0] high_int;
  logic cmp_under;
  logic cmp_over;
  logic set_under;
  logic set_over;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;

  atc_cmp u_cmp (
    .result_i(RESULT_I),
    .low_field_i(low_field_q),
    .high_field_i(high_field_q),
    .low_int_o(low_int),
    .high_int_o(high_int),
    .under_o(cmp_under),
    .over_o(cmp_over)
  );

  assign aw_fire = AWVALID_I & awready_q;
  assign w_fire = WVALID_I & wready_q;
  assign ar_fire = ARVALID_I & arready_q;
  assign do_wr = aw_full_q & w_full_q & ~bvalid_q;

  // A threshold write lands only when the full low half-word is written
  // and its address code matches the register selected by the offset.
  assign wr_low_ok = (awaddr_q == OFS_LOW) &&
    (wstrb_q[1:0] == STRB_LOW_HALF) &&
    (wdata_q[CODE_MSB:CODE_LSB] == CODE_LOW);
  assign wr_high_ok = (awaddr_q == OFS_HIGH) &&
    (wstrb_q[1:0] == STRB_LOW_HALF) &&
    (wdata_q[CODE_MSB:CODE_LSB] == CODE_HIGH);
  assign wr_ok = wr_low_ok | wr_high_ok;

  // Write channel bookkeeping: address and data may come in either order.
  always_comb begin
    aw_full_d = do_wr ? 1'b0 : (aw_full_q | aw_fire);
    w_full_d = do_wr ? 1'b0 : (w_full_q | w_fire);
    bvalid_d = do_wr ? 1'b1 : (bvalid_q & ~BREADY_I);
    awready_d = ~aw_full_d & ~bvalid_d;
    wready_d = ~w_full_d & ~bvalid_d;
    rvalid_d = ar_fire | (rvalid_q & ~RREADY_I);
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (CE_I) begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      if (do_wr) begin
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (CE_I) begin
      if (aw_fire) begin
        awaddr_q <= AWADDR_I;
      end
      if (w_fire) begin
        wdata_q <= WDATA_I;
        wstrb_q <= WSTRB_I;
      end
    end
  end

  // Threshold fields.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      low_field_q <= LOW_RST;
      high_field_q <= HIGH_RST;
    end else if (CE_I && do_wr) begin
      if (wr_low_ok) begin
        low_field_q <= wdata_q[FIELD_MSB:FIELD_LSB];
      end
      if (wr_high_ok) begin
        high_field_q <= wdata_q[FIELD_MSB:FIELD_LSB];
      end
    end
  end

  // Sticky flags: a new alert in the clearing cycle survives the clear.
  assign flag_clear = ar_fire && (ARADDR_I == OFS_FLAGS);
  assign set_under = RESULT_VLD_I & cmp_under;
  assign set_over = RESULT_VLD_I & cmp_over;

  always_comb begin
    chan0_under_flag_d = (chan0_under_flag_q & ~flag_clear) | set_under;
    chan0_over_flag_d = (chan0_over_flag_q & ~flag_clear) | set_over;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      chan0_under_flag_q <= 1'b0;
      chan0_over_flag_q <= 1'b0;
      UNDER_FLAG_O <= 1'b0;
      OVER_FLAG_O <= 1'b0;
    end else if (CE_I) begin
      chan0_under_flag_q <= chan0_under_flag_d;
      chan0_over_flag_q <= chan0_over_flag_d;
      UNDER_FLAG_O <= chan0_under_flag_d;
      OVER_FLAG_O <= chan0_over_flag_d;
    end
  end

  // Read decode; each mapped word reports its own address code in bits 15:12, unmapped reads return zero.
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (ARADDR_I)
      OFS_FLAGS: begin
        rd_word[CODE_MSB:CODE_LSB] = CODE_FLAGS;
        rd_word[OVER_BIT] = chan0_over_flag_q;
        rd_word[UNDER_BIT] = chan0_under_flag_q;
      end
      OFS_LOW: begin
        rd_word[CODE_MSB:CODE_LSB] = CODE_LOW;
        rd_word[FIELD_MSB:FIELD_LSB] = low_field_q;
      end
      OFS_HIGH: begin
        rd_word[CODE_MSB:CODE_LSB] = CODE_HIGH;
        rd_word[FIELD_MSB:FIELD_LSB] = high_field_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (CE_I) begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      if (ar_fire) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign AWREADY_O = awready_q;
  assign WREADY_O = wready_q;
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O = rvalid_q;
  assign RDATA_O = rdata_q;
  assign RRESP_O = rresp_q;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  over_sets_a: assert property (
    CE_I && RESULT_VLD_I && (RESULT_I > high_int)
    |=> chan0_over_flag_q && OVER_FLAG_O)
    else $error("Over flag not set by a result above the high threshold.");

  over_holds_a: assert property (
    CE_I && chan0_over_flag_q && !flag_clear
    |=> chan0_over_flag_q)
    else $error("Over flag dropped without a flag register read.");

  under_sets_a: assert property (
    CE_I && RESULT_VLD_I && (RESULT_I < low_int)
    |=> chan0_under_flag_q && UNDER_FLAG_O)
    else $error("Under flag not set by a result below the low threshold.");

  flag_read_clears_a: assert property (
    CE_I && flag_clear && !RESULT_VLD_I
    |=> !chan0_under_flag_q && !chan0_over_flag_q ##0
        rvalid_q && rdata_q[CODE_MSB:CODE_LSB] == CODE_FLAGS)
    else $error("Flag read did not clear the flags or return the code.");

  low_thresh_shape_a: assert property (
    CE_I && do_wr && wr_low_ok
    |=> low_int == {$past(wdata_q[FIELD_MSB:FIELD_LSB]), 4'h0})
    else $error("Low threshold not widened with a zero nibble.");

  high_thresh_shape_a: assert property (
    CE_I && do_wr && wr_high_ok
    |=> high_int == {$past(wdata_q[FIELD_MSB:FIELD_LSB]), 4'hF})
    else $error("High threshold not widened with a ones nibble.");

  no_false_under_a: assert property (
    CE_I && RESULT_VLD_I && (RESULT_I > low_int) &&
    !chan0_under_flag_q
    |=> !chan0_under_flag_q)
    else $error("Under flag set by a result above the low threshold.");

  no_false_over_a: assert property (
    CE_I && RESULT_VLD_I && (RESULT_I < high_int) &&
    !chan0_over_flag_q
    |=> !chan0_over_flag_q)
    else $error("Over flag set by a result below the high threshold.");

  code_mismatch_a: assert property (
    CE_I && do_wr && (awaddr_q == OFS_LOW) &&
    (wdata_q[CODE_MSB:CODE_LSB] != CODE_LOW)
    |=> $stable(low_field_q) ##0 bvalid_q && bresp_q == RESP_SLVERR)
    else $error("Low write with a wrong address code was not refused.");

  reset_values_a: assert property (
    $past(RST_I) |-> low_field_q == LOW_RST && high_field_q == HIGH_RST)
    else $error("Threshold fields did not come out of reset at defaults.");
endmodule : atc_top

// ==== atc_pkg.sv ====
package atc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 16;
  localparam int FIELD_W = 12;
  localparam int CODE_W = 4;

  // Byte offsets on the register bus.
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 8'h08;

  // Register address codes carried in bits 15:12 of each register word.
  localparam logic [CODE_W-1:0] CODE_FLAGS = 4'h1;
  localparam logic [CODE_W-1:0] CODE_LOW = 4'h2;
  localparam logic [CODE_W-1:0] CODE_HIGH = 4'h3;
  localparam int CODE_LSB = 12;
  localparam int CODE_MSB = 15;

  // Field layout.
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 11;
  localparam int UNDER_BIT = 0;
  localparam int OVER_BIT = 1;
  localparam logic [3:0] LOW_PAD = 4'h0;
  localparam logic [3:0] HIGH_PAD = 4'hF;

  // Reset values.
  localparam logic [FIELD_W-1:0] LOW_RST = 12'h800;
  localparam logic [FIELD_W-1:0] HIGH_RST = 12'hFFF;

  // Bus responses.
  typedef logic [1:0] atc_resp_t;
  localparam atc_resp_t RESP_OKAY = 2'h0;
  localparam atc_resp_t RESP_SLVERR = 2'h2;
  localparam logic [1:0] STRB_LOW_HALF = 2'h3;
endpackage : atc_pkg

// ==== atc_cmp.sv ====
`timescale 1ns/1ps
module atc_cmp
  import atc_pkg::*;
(
  input wire logic [RES_W-1:0] result_i,
  input wire logic [FIELD_W-1:0] low_field_i,
  input wire logic [FIELD_W-1:0] high_field_i,
  output logic [RES_W-1:0] low_int_o,
  output logic [RES_W-1:0] high_int_o,
  output logic under_o,
  output logic over_o
);
  assign low_int_o = {low_field_i, LOW_PAD};
  assign high_int_o = {high_field_i, HIGH_PAD};
  assign under_o = (result_i < low_int_o);
  assign over_o = (result_i > high_int_o);
endmodule : atc_cmp

// ==== atc_host.sv ====
`timescale 1ns/1ps
module atc_host
  import atc_pkg::*;
(
  input wire logic clk_i,
  input wire logic awready_i,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  input wire logic arready_i,
  input wire logic [DATA_W-1:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic [ADDR_W-1:0] awaddr_o,
  output logic awvalid_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  output logic bready_o,
  output logic [ADDR_W-1:0] araddr_o,
  output logic arvalid_o,
  output logic rready_o
);
  // Cycles of delay before the response channel is accepted.
  int stall = 0;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
    {bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [3:0] s, output atc_resp_t r);
    logic ta, tw, done;
    int n;
    n = 0;
    done = 0;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= (stall == 0);
    while (!done) begin
      @(negedge clk_i);
      ta = awvalid_o && awready_i;
      tw = wvalid_o && wready_i;
      done = bvalid_i && bready_o;
      r = bresp_i;
      @(posedge clk_i);
      n++;
      // Released lines show the inverse so stale values cannot match.
      if (ta) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (tw) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      bready_o <= !done && n >= stall;
    end
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a,
      output logic [DATA_W-1:0] d, output atc_resp_t r);
    logic ta, done;
    int n;
    n = 0;
    done = 0;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= (stall == 0);
    while (!done) begin
      @(negedge clk_i);
      ta = arvalid_o && arready_i;
      done = rvalid_i && rready_o;
      d = rdata_i;
      r = rresp_i;
      @(posedge clk_i);
      n++;
      if (ta) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      rready_o <= !done && n >= stall;
    end
  endtask : rd
endmodule : atc_host

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
  end end
module tb
  import atc_pkg::*;
;
  typedef struct {logic [RES_W-1:0] v; logic o; logic u;} atc_row_t;
  logic clk, rst, vld, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, ov, un, ce;
  logic [RES_W-1:0] res;
  logic [ADDR_W-1:0] awa, ara;
  logic [DATA_W-1:0] wd, rdt, d;
  logic [3:0] ws;
  atc_resp_t bre, rre, r;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Thresholds 0x4000 and 0xC00F; both equal values give no alert.
  atc_row_t rows [8] = '{'{16'h3FFF, 1'b0, 1'b1}, '{16'h4000, 1'b0, 1'b0},
    '{16'h4001, 1'b0, 1'b0}, '{16'hC008, 1'b0, 1'b0},
    '{16'hC00F, 1'b0, 1'b0}, '{16'hC010, 1'b1, 1'b0},
    '{16'h0000, 1'b0, 1'b1}, '{16'hFFFF, 1'b1, 1'b0}};
  atc_top atc_top_i (.MCLK_I(clk), .RST_I(rst), .CE_I(ce),
    .RESULT_I(res), .RESULT_VLD_I(vld), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv),
    .WREADY_O(wr), .BRESP_O(bre), .BVALID_O(bv), .BREADY_I(br),
    .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdt),
    .RRESP_O(rre), .RVALID_O(rv), .RREADY_I(rr), .OVER_FLAG_O(ov),
    .UNDER_FLAG_O(un));
  atc_host atc_host_i (.clk_i(clk), .awready_i(awr), .wready_i(wr),
    .bresp_i(bre), .bvalid_i(bv), .arready_i(arr), .rdata_i(rdt),
    .rresp_i(rre), .rvalid_i(rv), .awaddr_o(awa), .awvalid_o(awv),
    .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .bready_o(br),
    .araddr_o(ara), .arvalid_o(arv), .rready_o(rr));
  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic put(input logic [RES_W-1:0] v);
    @(posedge clk);
    res <= v;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    res <= ~v;
    @(negedge clk);
  endtask : put
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    vld = 1'b0;
    res = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    atc_host_i.rd(OFS_LOW, d, r);
    `CHK(d, {16'h0000, CODE_LOW, LOW_RST})
    atc_host_i.rd(OFS_HIGH, d, r);
    `CHK(d, {16'h0000, CODE_HIGH, HIGH_RST})
    atc_host_i.rd(OFS_FLAGS, d, r);
    `CHK(d, {16'h0000, CODE_FLAGS, 12'h000})
    atc_host_i.stall = 2;
    atc_host_i.wr(OFS_LOW, {16'h0000, CODE_LOW, 12'h400}, 4'hF, r);
    `CHK(r, RESP_OKAY)
    atc_host_i.wr(OFS_HIGH, {16'h0000, CODE_HIGH, 12'hC00}, 4'h3, r);
    `CHK(r, RESP_OKAY)
    atc_host_i.stall = 0;
    foreach (rows[i]) begin
      put(rows[i].v);
      put(16'h8000);
      `CHK({ov, un}, {rows[i].o, rows[i].u})
      atc_host_i.rd(OFS_FLAGS, d, r);
      `CHK(d, {16'h0000, CODE_FLAGS, 10'h000, rows[i].o, rows[i].u})
      @(negedge clk);
      `CHK({ov, un}, 2'h0)
    end
    // A new alert in the very cycle of a clearing read must survive it.
    fork
      atc_host_i.rd(OFS_FLAGS, d, r);
      put(16'h0000);
    join
    `CHK(d, {16'h0000, CODE_FLAGS, 12'h000})
    `CHK(un, 1'b1)
    atc_host_i.rd(OFS_FLAGS, d, r);
    `CHK(d, {16'h0000, CODE_FLAGS, 12'h001})
    // With the clock enable low a result above the threshold is ignored.
    @(posedge clk);
    ce <= 1'b0;
    put(16'hFFFF);
    `CHK(ov, 1'b0)
    @(posedge clk);
    ce <= 1'b1;
    atc_host_i.wr(OFS_LOW, {16'h0000, CODE_HIGH, 12'h123}, 4'hF, r);
    `CHK(r, RESP_SLVERR)
    atc_host_i.wr(OFS_HIGH, {16'h0000, CODE_HIGH, 12'h123}, 4'h1, r);
    `CHK(r, RESP_SLVERR)
    atc_host_i.wr(OFS_FLAGS, {16'h0000, CODE_FLAGS, 12'h003}, 4'hF, r);
    `CHK(r, RESP_SLVERR)
    atc_host_i.rd(8'h0C, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
    atc_host_i.rd(OFS_LOW, d, r);
    `CHK(d, {16'h0000, CODE_LOW, 12'h400})
    atc_host_i.rd(OFS_HIGH, d, r);
    `CHK(d, {16'h0000, CODE_HIGH, 12'hC00})
    put(16'h0000);
    `CHK(un, 1'b1)
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(un, 1'b0)
    atc_host_i.rd(OFS_LOW, d, r);
    `CHK(d, {16'h0000, CODE_LOW, LOW_RST})
    tally_and_finish();
  end
endmodule : tb
